// [design/mdsel_defines.vh]
// constants of the monitor display selector: parameter indices, reset
// values, unit lamp codes and encoder timing.
// assumes plain verilog-2005 and inclusion by bare name.
`ifndef MDSEL_DEFINES_VH
`define MDSEL_DEFINES_VH

// parameter indices within the display group
`define MDS_IDX_LANG 5'h00
`define MDS_IDX_FIRST 5'h01
`define MDS_IDX_LAST 5'h13
`define MDS_IDX_PON 5'h14
`define MDS_NOBJ 19

// display objects by index
`define MDS_OBJ_NONE 5'h00
`define MDS_OBJ_FPRE 5'h01
`define MDS_OBJ_FACT 5'h02
`define MDS_OBJ_CURR 5'h03
`define MDS_OBJ_FREF 5'h04
`define MDS_OBJ_RSPD 5'h05
`define MDS_OBJ_RREF 5'h06
`define MDS_OBJ_LSPD 5'h07
`define MDS_OBJ_LREF 5'h08
`define MDS_OBJ_POW 5'h09
`define MDS_OBJ_TRQ 5'h0A
`define MDS_OBJ_VOUT 5'h0B
`define MDS_OBJ_VBUS 5'h0C
`define MDS_OBJ_AIN1 5'h0D
`define MDS_OBJ_AIN2 5'h0E
`define MDS_OBJ_PFB 5'h0F
`define MDS_OBJ_PSET 5'h10
`define MDS_OBJ_CNT 5'h11
`define MDS_OBJ_TERM 5'h12
`define MDS_OBJ_LEN 5'h13

// reset values: enables bit n is object n, bit 0 unused
`define MDS_RST_LANG 1'h0
`define MDS_RST_SHOW 20'h0001A
`define MDS_RST_PON 5'h01

// unit lamps {flash, v, a, hz}
`define MDS_U_OFF 4'h0
`define MDS_U_HZ 4'h1
`define MDS_U_A 4'h2
`define MDS_U_V 4'h4
`define MDS_U_HZF 4'h9
`define MDS_U_RPM 4'h3
`define MDS_U_RPMF 4'hB
`define MDS_U_MPS 4'h6
`define MDS_U_ALL 4'h7
`define MDS_U_ALLF 4'hF

// source selections
`define MDS_FSRC_KEYPAD 4'h1
`define MDS_PREF_KEYPAD 4'h0
`define MDS_PFB_PULSE 4'h9

// save targets
`define MDS_TGT_PRESET 2'h0
`define MDS_TGT_PIDSPD 2'h1
`define MDS_TGT_PIDANA 2'h2

// encoder step sizes in 0.01 hz units and tier thresholds
`define MDS_STEP_FINE 7'h01
`define MDS_STEP_MED 7'h0A
`define MDS_STEP_MAX 7'h64
`define MDS_TIER1 5'h0A
`define MDS_TIER2 5'h14

// idle gap that ends a burst of turning
`define MDS_GAP_MS 200
`define MDS_CLK_KHZ 125000

// terminal pattern layout
`define MDS_SEG_CENTRE 4'hF
`define MDS_SMALL_IN_MASK 8'h1F
`define MDS_SMALL_OC_MASK 3'h1
`define MDS_SMALL_RL_MASK 2'h1

`endif

// [design/mdsel_sync.v]
// two-stage synchroniser for a vector of pin levels.
// assumes one clock; the enable freezes both stages.
`timescale 1ns/1ps
`default_nettype none
module mdsel_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_ce,
  input wire [WIDTH-1:0] i_d,
  output reg [WIDTH-1:0] o_q
);
  reg [WIDTH-1:0] meta;

  // first stage feeds only the second
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta <= {WIDTH{1'b0}};
      o_q <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // mdsel_sync
`default_nettype wire

// [design/mdsel_top.v]
// keypad monitor display selector: object enables, unit lamps, online
// adjust and save, terminal pattern and panel language.
// assumes keys, encoder and terminals arrive as asynchronous pins and
// drive settings come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "mdsel_defines.vh"

module mdsel_top #(
  parameter GAP_CYC = `MDS_GAP_MS * `MDS_CLK_KHZ
) (
  input wire I_REF_CLK,
  input wire I_RESET_N,
  input wire I_CLK_EN,
  input wire I_PARAM_WR,
  input wire [4:0] I_PARAM_IDX,
  input wire [4:0] I_PARAM_DATA,
  input wire I_KEY_SHIFT,
  input wire I_KEY_ENTER,
  input wire I_ENC_UP,
  input wire I_ENC_DOWN,
  input wire I_PID_RUN_MODE,
  input wire I_LARGE_MODEL,
  input wire [3:0] I_FREQ_SOURCE_SELECT,
  input wire [3:0] I_PID_REFERENCE_SOURCE,
  input wire [3:0] I_PID_FEEDBACK_SOURCE,
  input wire [7:0] I_TERM_IN,
  input wire [2:0] I_OC_OUT,
  input wire [1:0] I_RELAY_OUT,
  output reg O_LANG_ENGLISH,
  output reg [4:0] O_OBJECT,
  output reg O_LED_HZ,
  output reg O_LED_A,
  output reg O_LED_V,
  output reg O_LED_FLASH,
  output reg O_ADJ_ALLOW,
  output reg O_ADJ_VALID,
  output reg O_ADJ_DOWN,
  output reg [6:0] O_ADJ_STEP,
  output reg O_SAVE,
  output reg [1:0] O_SAVE_TARGET,
  output reg [16:0] O_TERM_SEG
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  reg [19:0] show_en;
  reg [4:0] power_on_display_select;
  reg started;
  reg [4:0] obj;
  reg shift_d, enter_d, up_d, down_d;
  reg [4:0] burst;
  reg [24:0] gap;
  reg next_allow;
  reg [1:0] next_target;
  reg [6:0] next_step;
  wire [3:0] key_sync;
  wire [7:0] term_sync;
  wire [2:0] oc_sync;
  wire [1:0] relay_sync;
  wire shift_rise, enter_rise, up_rise, down_rise, turn;
  wire [3:0] units;
  wire keypad_src, pid_kp_ref, fb_pulse;

  ////////////////////////////////////////////////////////////////////////
  // decode functions

  // first enabled object after 'from', wrapping past the last
  function [4:0] find_next;
    input [19:0] en;
    input [4:0] from;
    integer k;
    reg [4:0] cand;
    reg found;
    begin
      find_next = `MDS_OBJ_NONE;
      found = 1'b0;
      cand = from;
      for (k = 0; k < `MDS_NOBJ; k = k + 1) begin
        if (cand >= `MDS_IDX_LAST)
          cand = `MDS_IDX_FIRST;
        else
          cand = cand + 5'h01;
        if (!found && en[cand]) begin
          find_next = cand;
          found = 1'b1;
        end
      end
    end
  endfunction

  // unit lamp code {flash, v, a, hz} for an object
  function [3:0] unit_code;
    input [4:0] o;
    begin
      case (o)
        `MDS_OBJ_FPRE: unit_code = `MDS_U_HZ;
        `MDS_OBJ_FACT: unit_code = `MDS_U_HZ;
        `MDS_OBJ_CURR: unit_code = `MDS_U_A;
        `MDS_OBJ_FREF: unit_code = `MDS_U_HZF;
        `MDS_OBJ_RSPD: unit_code = `MDS_U_RPM;
        `MDS_OBJ_RREF: unit_code = `MDS_U_RPMF;
        `MDS_OBJ_LSPD: unit_code = `MDS_U_MPS;
        `MDS_OBJ_LREF: unit_code = `MDS_U_MPS;
        `MDS_OBJ_POW: unit_code = `MDS_U_OFF;
        `MDS_OBJ_TRQ: unit_code = `MDS_U_OFF;
        `MDS_OBJ_VOUT: unit_code = `MDS_U_V;
        `MDS_OBJ_VBUS: unit_code = `MDS_U_V;
        `MDS_OBJ_AIN1: unit_code = `MDS_U_V;
        `MDS_OBJ_AIN2: unit_code = `MDS_U_V;
        `MDS_OBJ_PFB: unit_code = `MDS_U_ALL;
        `MDS_OBJ_PSET: unit_code = `MDS_U_ALLF;
        `MDS_OBJ_CNT: unit_code = `MDS_U_OFF;
        `MDS_OBJ_LEN: unit_code = `MDS_U_OFF;
        default: unit_code = `MDS_U_OFF;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  mdsel_sync #(.WIDTH(4)) u_key_sync (
    .i_clk(I_REF_CLK),
    .i_reset_n(I_RESET_N),
    .i_ce(I_CLK_EN),
    .i_d({I_ENC_DOWN, I_ENC_UP, I_KEY_ENTER, I_KEY_SHIFT}),
    .o_q(key_sync)
  );

  mdsel_sync #(.WIDTH(13)) u_term_sync (
    .i_clk(I_REF_CLK),
    .i_reset_n(I_RESET_N),
    .i_ce(I_CLK_EN),
    .i_d({I_RELAY_OUT, I_OC_OUT, I_TERM_IN}),
    .o_q({relay_sync, oc_sync, term_sync})
  );

  // rising edges of the synchronised keys
  assign shift_rise = key_sync[0] & ~shift_d;
  assign enter_rise = key_sync[1] & ~enter_d;
  assign up_rise = key_sync[2] & ~up_d;
  assign down_rise = key_sync[3] & ~down_d;
  assign turn = up_rise | down_rise;

  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      shift_d <= 1'b0;
      enter_d <= 1'b0;
      up_d <= 1'b0;
      down_d <= 1'b0;
    end else if (I_CLK_EN) begin
      shift_d <= key_sync[0];
      enter_d <= key_sync[1];
      up_d <= key_sync[2];
      down_d <= key_sync[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // display parameters, written by index from keypad or serial link

  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_LANG_ENGLISH <= `MDS_RST_LANG;
      power_on_display_select <= `MDS_RST_PON;
    end else if (I_CLK_EN && I_PARAM_WR) begin
      if (I_PARAM_IDX == `MDS_IDX_LANG)
        O_LANG_ENGLISH <= I_PARAM_DATA[0];
      // out-of-range values are ignored, keeping a valid start object
      if (I_PARAM_IDX == `MDS_IDX_PON && I_PARAM_DATA >= `MDS_IDX_FIRST &&
          I_PARAM_DATA <= `MDS_IDX_LAST)
        power_on_display_select <= I_PARAM_DATA;
    end
  end

  // one enable bit per object
  genvar g;
  generate
    for (g = 0; g < 20; g = g + 1) begin : g_show
      always @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N)
          show_en[g] <= |((`MDS_RST_SHOW >> g) & 20'h00001);
        else if (I_CLK_EN && I_PARAM_WR && g != 0 &&
                 I_PARAM_IDX == g)
          show_en[g] <= I_PARAM_DATA[0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // object selection: power-on start, then shift stepping

  // the start search runs once after reset, from the chosen object on
  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      started <= 1'b0;
      obj <= `MDS_OBJ_NONE;
    end else if (I_CLK_EN) begin
      if (!started) begin
        started <= 1'b1;
        obj <= find_next(show_en,
                 power_on_display_select - 5'h01);
      end else if (shift_rise || !show_en[obj]) begin
        // a disabled current object also moves on, so none stays stale
        obj <= find_next(show_en, obj);
      end
    end
  end

  assign units = unit_code(obj);

  ////////////////////////////////////////////////////////////////////////
  // online adjust permission and save target

  assign keypad_src = (I_FREQ_SOURCE_SELECT == `MDS_FSRC_KEYPAD);
  assign pid_kp_ref = (I_PID_REFERENCE_SOURCE == `MDS_PREF_KEYPAD);
  assign fb_pulse = (I_PID_FEEDBACK_SOURCE == `MDS_PFB_PULSE);

  always @* begin
    next_allow = 1'b0;
    next_target = `MDS_TGT_PRESET;
    case (obj)
      `MDS_OBJ_FREF: begin
        next_allow = keypad_src;
      end
      `MDS_OBJ_RSPD, `MDS_OBJ_RREF: begin
        // speed paths count only while reference speed display is enabled
        if (show_en[`MDS_OBJ_RREF]) begin
          if (!I_PID_RUN_MODE) begin
            next_allow = keypad_src;
          end else begin
            next_allow = pid_kp_ref && fb_pulse;
            next_target = `MDS_TGT_PIDSPD;
          end
        end
      end
      `MDS_OBJ_PFB, `MDS_OBJ_PSET: begin
        if (show_en[`MDS_OBJ_PSET]) begin
          next_allow = pid_kp_ref && !fb_pulse;
          next_target = `MDS_TGT_PIDANA;
        end
      end
      `MDS_OBJ_LREF: begin
        next_allow = 1'b0;
      end
      default: begin
        next_allow = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // encoder step growth: detents within one burst raise the step size

  always @* begin
    if (burst >= `MDS_TIER2)
      next_step = `MDS_STEP_MAX;
    else if (burst >= `MDS_TIER1)
      next_step = `MDS_STEP_MED;
    else
      next_step = `MDS_STEP_FINE;
  end

  // an idle gap ends the burst so a fresh turn starts fine again
  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      burst <= 5'h00;
      gap <= 25'h0000000;
    end else if (I_CLK_EN) begin
      if (turn && next_allow) begin
        gap <= GAP_CYC[24:0];
        if (burst < `MDS_TIER2)
          burst <= burst + 5'h01;
      end else if (gap != 25'h0000000) begin
        gap <= gap - 25'h0000001;
      end else begin
        burst <= 5'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_OBJECT <= `MDS_OBJ_NONE;
      O_LED_HZ <= 1'b0;
      O_LED_A <= 1'b0;
      O_LED_V <= 1'b0;
      O_LED_FLASH <= 1'b0;
      O_ADJ_ALLOW <= 1'b0;
      O_ADJ_VALID <= 1'b0;
      O_ADJ_DOWN <= 1'b0;
      O_ADJ_STEP <= `MDS_STEP_FINE;
      O_SAVE <= 1'b0;
      O_SAVE_TARGET <= `MDS_TGT_PRESET;
    end else if (I_CLK_EN) begin
      O_OBJECT <= obj;
      O_LED_HZ <= units[0];
      O_LED_A <= units[1];
      O_LED_V <= units[2];
      O_LED_FLASH <= units[3];
      O_ADJ_ALLOW <= next_allow;
      // both directions at once cancel; the panel never sends that
      O_ADJ_VALID <= next_allow && (up_rise ^ down_rise);
      O_ADJ_DOWN <= down_rise;
      O_ADJ_STEP <= next_step;
      O_SAVE <= next_allow && enter_rise;
      O_SAVE_TARGET <= next_target;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // terminal status pattern {relays, oc outputs, inputs, centre}

  // small models mask the terminals they do not have
  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_TERM_SEG <= 17'h00000;
    end else if (I_CLK_EN) begin
      if (obj == `MDS_OBJ_TERM) begin
        if (I_LARGE_MODEL)
          O_TERM_SEG <= {relay_sync, oc_sync, term_sync,
                         `MDS_SEG_CENTRE};
        else
          O_TERM_SEG <= {relay_sync & `MDS_SMALL_RL_MASK,
                         oc_sync & `MDS_SMALL_OC_MASK,
                         term_sync & `MDS_SMALL_IN_MASK,
                         `MDS_SEG_CENTRE};
      end else begin
        O_TERM_SEG <= 17'h00000;
      end
    end
  end

endmodule // mdsel_top
`default_nettype wire

// [tb/mdsel_monitor.sv]
// checker for the monitor display selector, bound to its top module.
// assumes one clock domain and the top module's port names.
`timescale 1ns/1ps
`default_nettype none
module mdsel_check (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CLK_EN,
  input wire logic I_PARAM_WR,
  input wire logic [4:0] I_PARAM_IDX,
  input wire logic [4:0] I_PARAM_DATA,
  input wire logic I_ENC_UP,
  input wire logic I_ENC_DOWN,
  input wire logic I_LARGE_MODEL,
  input wire logic O_LANG_ENGLISH,
  input wire logic [4:0] O_OBJECT,
  input wire logic O_LED_HZ,
  input wire logic O_LED_A,
  input wire logic O_LED_V,
  input wire logic O_LED_FLASH,
  input wire logic O_ADJ_ALLOW,
  input wire logic O_ADJ_VALID,
  input wire logic O_ADJ_DOWN,
  input wire logic [6:0] O_ADJ_STEP,
  input wire logic O_SAVE,
  input wire logic [1:0] O_SAVE_TARGET,
  input wire logic [16:0] O_TERM_SEG
);
  // lamp code {flash, v, a, hz} per object, object 0 in the low nibble
  localparam logic [79:0] LAMP = 80'h000F744440066B392110;
  wire logic [3:0] lamps = {O_LED_FLASH, O_LED_V, O_LED_A, O_LED_HZ};
  wire logic data_lsb = I_PARAM_DATA[0];
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  //////////////////////////////////////////////////////////////////////
  // torque is taken with all lamps off, as the designer chose
  AST_LAMPS: assert property (
    O_OBJECT != 5'h00 |-> lamps == LAMP[O_OBJECT*4 +: 4])
    else $error("unit lamps wrong for shown object");
  AST_SEG_CENTRE: assert property (
    O_OBJECT == 5'h12 |-> O_TERM_SEG[3:0] == 4'hF)
    else $error("centre segments dark");
  AST_SEG_BLANK: assert property (
    O_OBJECT != 5'h12 |-> O_TERM_SEG == 17'h00000)
    else $error("segments lit off terminal page");
  // six cycles of margin cover the pin pipeline after a model change
  AST_SEG_SMALL: assert property (
    !I_LARGE_MODEL [*6] ##0 O_OBJECT == 5'h12 |->
    (O_TERM_SEG & 17'h16E00) == 17'h00000)
    else $error("small model lit a missing terminal");
  AST_ADJ_GATE: assert property (
    O_ADJ_VALID || O_SAVE |-> O_ADJ_ALLOW)
    else $error("adjust pulse without permission");
  AST_LREF_FIXED: assert property (
    O_OBJECT == 5'h08 |-> !O_ADJ_ALLOW)
    else $error("reference linear speed adjustable");
  AST_STEP_SET: assert property (
    O_ADJ_VALID |-> O_ADJ_STEP inside {7'h01, 7'h0A, 7'h64})
    else $error("illegal encoder step");
  AST_LANG: assert property (
    I_CLK_EN && I_PARAM_WR && I_PARAM_IDX == 5'h00 |=>
    O_LANG_ENGLISH == $past(data_lsb))
    else $error("language bit not taken");
  AST_ENC_RESP: assert property (
    I_CLK_EN && O_ADJ_ALLOW && $rose(I_ENC_UP) && !I_ENC_DOWN |->
    ##[1:4] (O_ADJ_VALID && !O_ADJ_DOWN))
    else $error("up detent not answered");
  C_SAVE_ANA: cover property (O_SAVE && O_SAVE_TARGET == 2'h2);
  C_STEP_MAX: cover property (O_ADJ_VALID && O_ADJ_STEP == 7'h64);
  C_TERM: cover property (O_OBJECT == 5'h12);
endmodule // mdsel_check
bind mdsel_top mdsel_check mdsel_check_inst (.*);
`default_nettype wire

// [tb/mdsel_panel.sv]
// keypad panel model: shift and enter keys and the encoder detents.
// assumes tap is called from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module mdsel_panel (
  input wire logic i_clk,
  output logic o_shift,
  output logic o_enter,
  output logic o_up,
  output logic o_down
);
  logic [3:0] keys = 4'h0; // {down, up, enter, shift}
  assign {o_down, o_up, o_enter, o_shift} = keys;
  //////////////////////////////////////////////////////////////////////
  // held two cycles, then four low so the synchroniser sees a release
  task automatic tap(input int k);
    @(posedge i_clk);
    keys[k] <= 1'b1;
    repeat (2) @(posedge i_clk);
    keys <= 4'h0;
    repeat (4) @(posedge i_clk);
  endtask
endmodule // mdsel_panel
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the monitor display selector.
// assumes a 20 cycle burst gap and the top module's port names.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [79:0] LAMP = 80'h000F744440066B392110;
  logic I_REF_CLK = 1'b0;
  logic I_RESET_N = 1'b0;
  logic I_CLK_EN, I_PARAM_WR, I_PID_RUN_MODE, I_LARGE_MODEL;
  logic [4:0] I_PARAM_IDX, I_PARAM_DATA;
  logic [3:0] I_FREQ_SOURCE_SELECT, I_PID_REFERENCE_SOURCE;
  logic [3:0] I_PID_FEEDBACK_SOURCE;
  logic [7:0] I_TERM_IN;
  logic [2:0] I_OC_OUT;
  logic [1:0] I_RELAY_OUT;
  wire logic I_KEY_SHIFT, I_KEY_ENTER, I_ENC_UP, I_ENC_DOWN;
  wire logic O_LANG_ENGLISH, O_LED_HZ, O_LED_A, O_LED_V, O_LED_FLASH;
  wire logic O_ADJ_ALLOW, O_ADJ_VALID, O_ADJ_DOWN, O_SAVE;
  wire logic [4:0] O_OBJECT;
  wire logic [6:0] O_ADJ_STEP;
  wire logic [1:0] O_SAVE_TARGET;
  wire logic [16:0] O_TERM_SEG;
  wire logic [8:0] shown = {O_OBJECT, O_LED_FLASH, O_LED_V, O_LED_A, O_LED_HZ};
  int err_total = 0;
  int check_count = 0;
  int seed = 21;
  int cur = 1;
  int cnt = 0;
  bit en [1:19];
  logic [16:0] ts;
  logic [9:0] rq [$];
  logic [9:0] eq [$];
  //////////////////////////////////////////////////////////////////////
  mdsel_top #(.GAP_CYC(20)) mdsel_top_inst (.*);
  mdsel_panel mdsel_panel_inst (
    .i_clk(I_REF_CLK),
    .o_shift(I_KEY_SHIFT),
    .o_enter(I_KEY_ENTER),
    .o_up(I_ENC_UP),
    .o_down(I_ENC_DOWN)
  );
  // 125 MHz clock
  initial begin
    forever #4 I_REF_CLK = ~I_REF_CLK;
  end
  // log every pulse; order and count are compared later
  always @(posedge I_REF_CLK) begin
    if (O_ADJ_VALID === 1'b1) rq.push_back({2'h1, O_ADJ_DOWN, O_ADJ_STEP});
    if (O_SAVE === 1'b1) rq.push_back({2'h2, 6'h00, O_SAVE_TARGET});
  end
  //////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge I_REF_CLK);
  endtask
  task automatic wp(input int i, input int d);
    @(posedge I_REF_CLK);
    I_PARAM_WR <= 1'b1;
    I_PARAM_IDX <= i[4:0];
    I_PARAM_DATA <= d[4:0];
    @(posedge I_REF_CLK);
    I_PARAM_WR <= 1'b0;
  endtask
  task automatic set(input logic p, input logic [3:0] f, r, b);
    @(posedge I_REF_CLK);
    I_PID_RUN_MODE <= p;
    I_FREQ_SOURCE_SELECT <= f;
    I_PID_REFERENCE_SOURCE <= r;
    I_PID_FEEDBACK_SOURCE <= b;
    cyc(4);
  endtask
  // the model steps to the next enabled object, wrapping after 19
  task automatic shift();
    mdsel_panel_inst.tap(0);
    #1;
    do
      cur = cur % 19 + 1;
    while (!en[cur]);
    chk(shown, {cur[4:0], LAMP[cur*4 +: 4]});
  endtask
  task automatic goto(input int n);
    repeat (19) if (cur != n) shift();
  endtask
  task automatic det(input int k);
    eq.push_back({2'h1, k == 3, cnt < 10 ? 7'h01 : cnt < 20 ? 7'h0A : 7'h64});
    cnt++;
    mdsel_panel_inst.tap(k);
  endtask
  task automatic enter(input logic [1:0] t);
    eq.push_back({2'h2, 6'h00, t});
    mdsel_panel_inst.tap(1);
  endtask
  task automatic chkq();
    chk(rq.size(), eq.size());
    while (rq.size() > 0 && eq.size() > 0)
      chk(rq.pop_front(), eq.pop_front());
    rq.delete();
    eq.delete();
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    I_CLK_EN <= 1'b1;
    I_PARAM_WR <= 1'b0;
    {I_PARAM_IDX, I_PARAM_DATA} <= 10'h000;
    {I_PID_RUN_MODE, I_LARGE_MODEL} <= 2'h0;
    {I_FREQ_SOURCE_SELECT, I_PID_REFERENCE_SOURCE} <= 8'h10;
    I_PID_FEEDBACK_SOURCE <= 4'h9;
    {I_TERM_IN, I_OC_OUT, I_RELAY_OUT} <= 13'h0000;
    cyc(4);
    I_RESET_N <= 1'b1;
    cyc(3);
    #1;
    chk({shown, O_LANG_ENGLISH}, {9'h011, 1'b0});
    wp(0, 1);
    #1;
    chk(O_LANG_ENGLISH, 1'b1);
    wp(0, 0);
    for (int i = 1; i < 20; i++) begin
      en[i] = 1'b1;
      wp(i, 1);
    end
    goto(4);
    repeat (25) det(2);
    det(3);
    cyc(40);
    cnt = 0;
    det(2);
    enter(0);
    set(0, 4'h0, 4'h0, 4'h9);
    mdsel_panel_inst.tap(2);
    mdsel_panel_inst.tap(1);
    chkq();
    goto(6);
    set(0, 4'h1, 4'h0, 4'h9);
    enter(0);
    set(1, 4'h0, 4'h0, 4'h9);
    cnt = 0;
    det(3);
    enter(1);
    set(1, 4'h0, 4'h0, 4'h3);
    mdsel_panel_inst.tap(1);
    // a non-keypad pid reference refuses the save as well
    set(1, 4'h0, 4'h2, 4'h9);
    mdsel_panel_inst.tap(1);
    set(1, 4'h0, 4'h0, 4'h3);
    chkq();
    goto(8);
    mdsel_panel_inst.tap(2);
    mdsel_panel_inst.tap(1);
    chkq();
    goto(16);
    enter(2);
    set(1, 4'h0, 4'h4, 4'h3);
    mdsel_panel_inst.tap(1);
    chkq();
    goto(18);
    for (int i = 0; i < 4; i++) begin
      @(posedge I_REF_CLK);
      I_LARGE_MODEL <= i[0];
      I_TERM_IN <= $random(seed);
      I_OC_OUT <= $random(seed);
      I_RELAY_OUT <= $random(seed);
      cyc(7);
      #1;
      ts = {I_RELAY_OUT, I_OC_OUT, I_TERM_IN, 4'hF};
      if (!I_LARGE_MODEL) ts = ts & 17'h091FF;
      chk(O_TERM_SEG, ts);
    end
    goto(1);
    // a press made while frozen is never seen, so the object must stay
    @(posedge I_REF_CLK);
    I_CLK_EN <= 1'b0;
    mdsel_panel_inst.tap(0);
    cyc(($random(seed) & 7) + 1);
    @(posedge I_REF_CLK);
    I_CLK_EN <= 1'b1;
    cyc(6);
    #1;
    chk(shown, {cur[4:0], LAMP[cur*4 +: 4]});
    repeat (3) begin
      for (int i = 1; i < 20; i++) begin
        en[i] = $random(seed) & 1 || i == cur;
        wp(i, en[i]);
      end
      repeat (6) shift();
    end
    test_done();
  end
  // a hang ends the run as a failure
  initial begin
    cyc(20000);
    err_total++;
    test_done();
  end
endmodule // testbench
`default_nettype wire
